/* File: pkg/pes_pkg.sv */
// Purpose: shared constants and types of the parity error status word block
// Assumes: 32-bit classic Wishbone register bus, one clock
// Notes:   word bit 1 of the printed layout is the msb (word index 31)
package pes_pkg;

  // ********************************
  // register map
  // ********************************
  localparam logic [7:0]  OFS_FLAGS   = 8'h00;         // live flags, read captures
  localparam logic [7:0]  OFS_CAPTURE = 8'h04;         // last captured word
  localparam logic [7:0]  OFS_ISTAT   = 8'h08;         // sticky event status, w1c
  localparam logic [7:0]  OFS_IMASK   = 8'h0C;         // interrupt mask
  localparam logic [31:0] RST_WORD    = 32'h0000_0000; // reset of every register
  localparam logic [31:0] UNUSED_MASK = 32'h0F00_0000; // printed bits 5 to 8

  // ********************************
  // field positions, printed bit numbers
  // ********************************
  localparam int DOC_MEMBUS  = 1;  // first of four memory bus flags
  localparam int DOC_CFATAL  = 9;  // fatal cache parity
  localparam int DOC_BCREC   = 10; // branch cache recoverable
  localparam int DOC_CDLO    = 11; // first of four low-byte cache data flags
  localparam int DOC_IDX_BLO = 15; // cache index element b low
  localparam int DOC_IDX_BHI = 16; // cache index element b high
  localparam int DOC_CDHI    = 17; // first of four high-byte cache data flags
  localparam int DOC_IDX_AHI = 21; // cache index element a high
  localparam int DOC_IDX_ALO = 22; // cache index element a low
  localparam int DOC_TB1_PL  = 23; // translation buffer element 1 pa low
  localparam int DOC_TBA_PL  = 24; // element a pa low
  localparam int DOC_TB1_AC  = 25; // element 1 access bits
  localparam int DOC_TB1_PID = 26; // element 1 process id
  localparam int DOC_TB1_TAG = 27; // element 1 virtual tag
  localparam int DOC_TBA_PH  = 28; // element a pa high
  localparam int DOC_TB1_PH  = 29; // element 1 pa high
  localparam int DOC_TBA_AC  = 30; // element a access bits
  localparam int DOC_TBA_PID = 31; // element a process id
  localparam int DOC_TBA_TAG = 32; // element a virtual tag

  // ********************************
  // event carrier, fields in printed order
  // ********************************
  typedef struct packed {
    logic [3:0] mem_bus;      // high left, high right, low left, low right
    logic       cache_fatal;  // control store, fatal cache parity
    logic       bcache_recov; // control store, branch cache recoverable
    logic [3:0] cdata_lo;     // b even, b odd, a even, a odd
    logic       idx_b_lo;     // index element b low byte
    logic       idx_b_hi;     // index element b high byte
    logic [3:0] cdata_hi;     // a even, a odd, b even, b odd
    logic       idx_a_hi;     // index element a high byte
    logic       idx_a_lo;     // index element a low byte
    logic [9:0] tb;           // translation buffer, printed bits 23 to 32
  } pes_evt_t;

  // printed bit number to word index
  function automatic int doc_idx(input int n);
    return 32 - n;
  endfunction : doc_idx

  // place the event pulses into the 32-bit layout, unused bits zero
  function automatic logic [31:0] evt_word(input pes_evt_t e);
    logic [27:0] raw;
    raw = e;
    return {raw[27:24], 4'h0, raw[23:0]};
  endfunction : evt_word

endpackage : pes_pkg

/* File: core/pes_status.sv */
// Purpose: parity error status word with capture, sticky events and interrupt
// Assumes: event inputs are one-cycle or level pulses synchronous to clk_i
// Notes:   single clock, synchronous active-high reset, Wishbone classic slave
//
// Notes on behaviour
// - bits 1-4 flag memory data bus bytes
// - bit 9 flags fatal cache parity
// - bit 10 flags branch cache recoverable error
// - bits 11-14 flag low-byte cache data
// - bits 15,16,21,22 flag cache index bytes
// - bits 17-20 flag high-byte cache data
// - element 1 buffer flags at 23,25,26,27,29
// - element a buffer flags at 24,28,30,31,32
// - bits 5-8 unused, always read zero
`timescale 1ns/1ps

module pes_status #(
  parameter int DW = 32                 // data width of the word
) (
  input  wire logic             clk_i,     // 250 MHz system clock
  input  wire logic             rst_i,     // synchronous reset, high
  input  wire pes_pkg::pes_evt_t evt_i,    // error reports, high for one cycle
  input  wire logic             wb_cyc_i,  // bus cycle
  input  wire logic             wb_stb_i,  // strobe
  input  wire logic             wb_we_i,   // write enable
  input  wire logic [7:0]       wb_adr_i,  // byte address
  input  wire logic [3:0]       wb_sel_i,  // byte lanes
  input  wire logic [DW-1:0]    wb_dat_i,  // write data
  output logic      [DW-1:0]    wb_dat_o,  // read data, registered
  output logic                  wb_ack_o,  // one-cycle acknowledge
  output logic                  irq_o      // level interrupt, registered
);

  // ********************************
  // state
  // ********************************
  logic [DW-1:0] flags_q;   // live sticky flags
  logic [DW-1:0] capt_q;    // word taken by the last capturing read
  logic [DW-1:0] istat_q;   // sticky event status for interrupts
  logic [DW-1:0] imask_q;   // interrupt enables
  logic [DW-1:0] set_w;     // this cycle's events in word layout
  logic          take_w;    // request taken this edge
  logic          cap_rd_w;  // capturing read of the flags word
  logic          st_wr_w;   // write to event status
  logic          mk_wr_w;   // write to mask
  logic [DW-1:0] bmask_w;   // byte-lane mask of a write

  // expand the byte selects into a bit mask
  function automatic logic [DW-1:0] lanes(input logic [3:0] sel);
    logic [DW-1:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction : lanes

  // ********************************
  // decode
  // ********************************
  // events mapped with bit 1 at the msb; unused lanes never set
  assign set_w    = pes_pkg::evt_word(evt_i);
  // a request is taken once; ack drops the cycle after it rose
  assign take_w   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign cap_rd_w = take_w & ~wb_we_i & (wb_adr_i == pes_pkg::OFS_FLAGS);
  assign st_wr_w  = take_w & wb_we_i & (wb_adr_i == pes_pkg::OFS_ISTAT);
  assign mk_wr_w  = take_w & wb_we_i & (wb_adr_i == pes_pkg::OFS_IMASK);
  assign bmask_w  = lanes(wb_sel_i);

  // ********************************
  // live flags
  // ********************************
  // flags stay until a capturing read; a new event in that same cycle
  // survives the clear, so no report is ever lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= pes_pkg::RST_WORD;
    end else if (cap_rd_w) begin
      flags_q <= set_w;
    end else begin
      flags_q <= flags_q | set_w;
    end
  end

  // ********************************
  // capture
  // ********************************
  // keeps the word software read, for a second look without losing it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capt_q <= pes_pkg::RST_WORD;
    end else if (cap_rd_w) begin
      capt_q <= flags_q;
    end
  end

  // ********************************
  // interrupt status and mask
  // ********************************
  // write one to clear; the set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      istat_q <= pes_pkg::RST_WORD;
    end else if (st_wr_w) begin
      istat_q <= (istat_q & ~(wb_dat_i & bmask_w)) | set_w;
    end else begin
      istat_q <= istat_q | set_w;
    end
  end

  // mask bits of the unused lanes cannot be set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      imask_q <= pes_pkg::RST_WORD;
    end else if (mk_wr_w) begin
      imask_q <= ((imask_q & ~bmask_w) | (wb_dat_i & bmask_w))
                 & ~pes_pkg::UNUSED_MASK;
    end
  end

  // irq lags status by one cycle, to come straight from a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(istat_q & imask_q);
    end
  end

  // ********************************
  // bus answer
  // ********************************
  // every access, mapped or not, is acked one cycle after it is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= take_w;
    end
  end

  // read mux; unmapped addresses and writes return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= pes_pkg::RST_WORD;
    end else if (take_w & ~wb_we_i) begin
      case (wb_adr_i)
        pes_pkg::OFS_FLAGS:   wb_dat_o <= flags_q;
        pes_pkg::OFS_CAPTURE: wb_dat_o <= capt_q;
        pes_pkg::OFS_ISTAT:   wb_dat_o <= istat_q;
        pes_pkg::OFS_IMASK:   wb_dat_o <= imask_q;
        default:              wb_dat_o <= pes_pkg::RST_WORD;
      endcase
    end else begin
      wb_dat_o <= pes_pkg::RST_WORD;
    end
  end

  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // a taken request is answered next edge, then ack falls
  sequence s_taken;
    take_w;
  endsequence
  sequence s_acked;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  AST_MEMBUS_HI_LEFT: assert property (
    evt_i.mem_bus[3] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_MEMBUS)])
    else $error("memory bus high left flag not set");

  AST_MEMBUS_LO_RIGHT: assert property (
    evt_i.mem_bus[0] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_MEMBUS + 3)])
    else $error("memory bus low right flag not set");

  AST_CACHE_FATAL: assert property (
    evt_i.cache_fatal |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_CFATAL)]
                        && istat_q[pes_pkg::doc_idx(pes_pkg::DOC_CFATAL)])
    else $error("fatal cache flag or status not set");

  AST_BCACHE_RECOV: assert property (
    evt_i.bcache_recov |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_BCREC)])
    else $error("branch cache flag not set");

  AST_CDATA_LO: assert property (
    evt_i.cdata_lo[0] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_CDLO + 3)])
    else $error("cache data low a odd flag not set");

  AST_CIDX: assert property (
    evt_i.idx_b_lo && evt_i.idx_a_hi |=>
      flags_q[pes_pkg::doc_idx(pes_pkg::DOC_IDX_BLO)]
      && flags_q[pes_pkg::doc_idx(pes_pkg::DOC_IDX_AHI)])
    else $error("cache index flags not set");

  AST_CDATA_HI: assert property (
    evt_i.cdata_hi[3] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_CDHI)])
    else $error("cache data high a even flag not set");

  AST_TB_ELEM1: assert property (
    evt_i.tb[3] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_TB1_PH)])
    else $error("element 1 pa high flag not set");

  AST_TB_ELEM1_TAG: assert property (
    evt_i.tb[5] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_TB1_TAG)])
    else $error("element 1 tag flag not set");

  AST_TB_ELEMA: assert property (
    evt_i.tb[0] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_TBA_TAG)])
    else $error("element a tag flag not set");

  AST_UNUSED: assert property (
    (flags_q & pes_pkg::UNUSED_MASK) == '0 && (istat_q & pes_pkg::UNUSED_MASK) == '0)
    else $error("unused bits became set");

  AST_STICKY: assert property (
    flags_q[31] && !cap_rd_w |=> flags_q[31])
    else $error("flag dropped without capture");

  AST_CAPTURE: assert property (
    cap_rd_w |=> capt_q == $past(flags_q) && wb_dat_o == $past(flags_q))
    else $error("capture does not match flags");

  AST_BUS_ACK: assert property (
    s_taken |=> s_acked)
    else $error("ack not a single cycle after request");

  AST_IRQ: assert property (
    |(istat_q & imask_q) |=> irq_o)
    else $error("irq missing for unmasked status");

  // ********************************
  // per-bit flag placement
  // ********************************
  // each report line lands on its own printed bit, so a swapped field is caught

  AST_MEMBUS_HI_RIGHT: assert property (
    evt_i.mem_bus[2] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_MEMBUS + 1)])
    else $error("memory bus high right flag not set");

  AST_MEMBUS_LO_LEFT: assert property (
    evt_i.mem_bus[1] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_MEMBUS + 2)])
    else $error("memory bus low left flag not set");

  AST_BCACHE_STATUS: assert property (
    evt_i.bcache_recov |=> istat_q[pes_pkg::doc_idx(pes_pkg::DOC_BCREC)])
    else $error("branch cache status not set");

  AST_CDATA_LO_B_EVEN: assert property (
    evt_i.cdata_lo[3] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_CDLO)])
    else $error("cache data low b even flag not set");

  AST_CDATA_LO_B_ODD: assert property (
    evt_i.cdata_lo[2] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_CDLO + 1)])
    else $error("cache data low b odd flag not set");

  AST_CDATA_LO_A_EVEN: assert property (
    evt_i.cdata_lo[1] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_CDLO + 2)])
    else $error("cache data low a even flag not set");

  AST_CIDX_B_HI: assert property (
    evt_i.idx_b_hi |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_IDX_BHI)])
    else $error("cache index b high flag not set");

  AST_CIDX_A_LO: assert property (
    evt_i.idx_a_lo |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_IDX_ALO)])
    else $error("cache index a low flag not set");

  AST_CDATA_HI_A_ODD: assert property (
    evt_i.cdata_hi[2] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_CDHI + 1)])
    else $error("cache data high a odd flag not set");

  AST_CDATA_HI_B_EVEN: assert property (
    evt_i.cdata_hi[1] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_CDHI + 2)])
    else $error("cache data high b even flag not set");

  AST_CDATA_HI_B_ODD: assert property (
    evt_i.cdata_hi[0] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_CDHI + 3)])
    else $error("cache data high b odd flag not set");

  AST_TB_ELEM1_PL: assert property (
    evt_i.tb[9] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_TB1_PL)])
    else $error("element 1 pa low flag not set");

  AST_TB_ELEM1_AC: assert property (
    evt_i.tb[7] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_TB1_AC)])
    else $error("element 1 access flag not set");

  AST_TB_ELEM1_PID: assert property (
    evt_i.tb[6] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_TB1_PID)])
    else $error("element 1 process id flag not set");

  AST_TB_ELEMA_PL: assert property (
    evt_i.tb[8] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_TBA_PL)])
    else $error("element a pa low flag not set");

  AST_TB_ELEMA_PH: assert property (
    evt_i.tb[4] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_TBA_PH)])
    else $error("element a pa high flag not set");

  AST_TB_ELEMA_AC: assert property (
    evt_i.tb[2] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_TBA_AC)])
    else $error("element a access flag not set");

  AST_TB_ELEMA_PID: assert property (
    evt_i.tb[1] |=> flags_q[pes_pkg::doc_idx(pes_pkg::DOC_TBA_PID)])
    else $error("element a process id flag not set");

  // ********************************
  // clearing, bus and interrupt
  // ********************************
  // apart from reset, a capturing read in a quiet cycle is the only way flags return to zero
  sequence s_cap_quiet;
    cap_rd_w && evt_i == '0;
  endsequence

  AST_FLAG_CLEAR: assert property (
    s_cap_quiet |=> flags_q == '0)
    else $error("flags not cleared by a capturing read");

  AST_MASK_UNUSED: assert property (
    (imask_q & pes_pkg::UNUSED_MASK) == '0
    && (wb_dat_o & pes_pkg::UNUSED_MASK) == '0)
    else $error("unused bits seen in mask or read data");

  AST_STATUS_W1C: assert property (
    st_wr_w && wb_sel_i == 4'hF && evt_i == '0 |=> (istat_q & $past(wb_dat_i)) == '0)
    else $error("status bits written with one not cleared");

  AST_IRQ_LOW: assert property (
    (istat_q & imask_q) == '0 |=> !irq_o)
    else $error("irq high with no unmasked status");

  AST_RDATA_IDLE: assert property (
    !wb_ack_o |-> wb_dat_o == '0)
    else $error("read data not zero outside the ack cycle");

  AST_ACK_NEEDS_REQ: assert property (
    wb_ack_o |-> $past(take_w))
    else $error("ack without a taken request");

endmodule : pes_status

/* File: tb/pes_evt_model.sv */
// Purpose: model of the internal error-reporting units that drive the event inputs
// Assumes: reports are launched just after a rising edge and last one cycle
// Notes:   reports are driven low when idle, never left floating
`timescale 1ns/1ps

module pes_evt_model (
  input  wire logic         clk_i,  // system clock
  output pes_pkg::pes_evt_t evt_o   // error reports to the block
);
  // ********************************
  // report driver
  // ********************************
  // quiet from time zero so no flag is set by an unknown
  initial begin
    evt_o = '0;
  end

  // pulse the given flags for exactly one cycle, then go quiet again
  task automatic fire(input logic [27:0] bits);
    @(posedge clk_i);
    evt_o <= bits;
    @(posedge clk_i);
    evt_o <= '0;
  endtask : fire
endmodule : pes_evt_model

/* File: tb/parity_error_status_word_bench.sv */
// Purpose: self-checking bench of the parity error status word over classic Wishbone
// Assumes: one 250 MHz clock, synchronous reset held for 10 cycles
// Notes:   expected words are built from printed bit numbers, bit 1 as msb
`timescale 1ns/1ps

module parity_error_status_word_bench;
  // ********************************
  // signals
  // ********************************
  logic              clk_i;     // system clock
  logic              rst_i;     // synchronous reset
  logic              cyc;       // bus cycle
  logic              stb;       // strobe
  logic              we;        // write enable
  logic [7:0]        adr;       // byte address
  logic [3:0]        sel;       // byte lanes
  logic [31:0]       wdat;      // write data
  logic [31:0]       dat_o;     // read data
  logic              ack;       // acknowledge
  logic              irq;       // interrupt level
  logic [31:0]       e;         // expected flag word
  pes_pkg::pes_evt_t evt;       // reports from the model
  pes_pkg::pes_evt_t ev;        // report built field by field
  int                fails;     // mismatches seen
  int                n_checks;  // comparisons made

  pes_status u_dut (.clk_i(clk_i), .rst_i(rst_i), .evt_i(evt), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq));
  pes_evt_model u_src (.clk_i(clk_i), .evt_o(evt));

  // ********************************
  // clock and watchdog
  // ********************************
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // the whole run needs well under 2000 cycles; a hang ends here
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    conclude();
  end

  // ********************************
  // tasks
  // ********************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; request held until ack is sampled high at an edge
  // no cycle limit here: only the watchdog ends a hung wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, 4'hF, q);
    chk(q, exp);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    wb(1'b1, a, d, s, q);
  endtask : wr

  // irq is checked two edges on, allowing the status stage and the irq stage
  task automatic chk_irq(input logic exp);
    repeat (2) @(posedge clk_i);
    chk({31'h0000_0000, irq}, {31'h0000_0000, exp});
  endtask : chk_irq

  // ********************************
  // main sequence
  // ********************************
  initial begin
    fails = 0;
    n_checks = 0;
    rst_i = 1'b1;
    {cyc, stb, we, adr, sel, wdat} = '0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(pes_pkg::OFS_FLAGS, pes_pkg::RST_WORD);     // reset value of the live flags
    rd(pes_pkg::OFS_CAPTURE, pes_pkg::RST_WORD);
    rd(pes_pkg::OFS_ISTAT, pes_pkg::RST_WORD);
    rd(pes_pkg::OFS_IMASK, pes_pkg::RST_WORD);
    // walk every used printed bit; unused 5 to 8 have no report line
    for (int n = 1; n <= 32; n++) begin
      if (n < 5 || n > 8) begin
        e = 32'h0000_0001 << (32 - n);
        u_src.fire((n < 5) ? (28'h000_0001 << (28 - n)) : (28'h000_0001 << (32 - n)));
        rd(pes_pkg::OFS_FLAGS, e);
        rd(pes_pkg::OFS_CAPTURE, e);
        rd(pes_pkg::OFS_FLAGS, 32'h0000_0000);
      end
    end
    // named fields against printed numbers: 2 high right, 20 b odd high, 22 index a low
    ev = '0;
    ev.mem_bus[2] = 1'b1;
    ev.cdata_hi[0] = 1'b1;
    ev.idx_a_lo = 1'b1;
    u_src.fire(ev);
    rd(pes_pkg::OFS_FLAGS, 32'h4000_1400);
    rd(pes_pkg::OFS_ISTAT, 32'hF0FF_FFFF);
    u_src.fire(28'hFFF_FFFF);
    rd(pes_pkg::OFS_FLAGS, 32'hF0FF_FFFF);
    chk_irq(1'b0);                         // status set but all masked
    wr(pes_pkg::OFS_IMASK, 32'hFFFF_FFFF, 4'h1);
    rd(pes_pkg::OFS_IMASK, 32'h0000_00FF); // only lane 0 written
    chk_irq(1'b1);
    wr(pes_pkg::OFS_ISTAT, 32'h0000_00FF, 4'hF);
    chk_irq(1'b0);
    rd(pes_pkg::OFS_ISTAT, 32'hF0FF_FF00);
    wr(pes_pkg::OFS_IMASK, 32'hFFFF_FFFF, 4'hF);
    rd(pes_pkg::OFS_IMASK, 32'hF0FF_FFFF);
    chk_irq(1'b1);
    wr(pes_pkg::OFS_ISTAT, 32'hFFFF_FFFF, 4'hF);
    rd(pes_pkg::OFS_ISTAT, 32'h0000_0000);
    chk_irq(1'b0);
    u_src.fire(28'h080_0000);              // fatal cache report alone
    chk_irq(1'b1);
    rd(pes_pkg::OFS_ISTAT, 32'h0080_0000);
    // unmapped place reads zero and ignores writes
    wr(8'h10, 32'hFFFF_FFFF, 4'hF);
    rd(8'h10, 32'h0000_0000);
    rd(pes_pkg::OFS_IMASK, 32'hF0FF_FFFF);
    rd(pes_pkg::OFS_ISTAT, 32'h0080_0000);
    // a second reset in mid-run drops the interrupt and the flags, status and mask registers
    u_src.fire(28'h080_0000);
    chk_irq(1'b1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_irq(1'b0);
    rd(pes_pkg::OFS_FLAGS, pes_pkg::RST_WORD);
    rd(pes_pkg::OFS_ISTAT, pes_pkg::RST_WORD);
    rd(pes_pkg::OFS_IMASK, pes_pkg::RST_WORD);
    conclude();
  end
endmodule : parity_error_status_word_bench
